// *** dct_cfg.svh ***
`ifndef DCT_CFG_SVH
`define DCT_CFG_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define DCT_OFF_CNT1      8'h00
`define DCT_OFF_CAP_FIRST 8'h04
`define DCT_OFF_CAP_SEC   8'h08
`define DCT_OFF_CNT2      8'h0C
`define DCT_OFF_PRESC     8'h10
`define DCT_OFF_CKSEL     8'h14
`define DCT_OFF_MCTRL     8'h18
`define DCT_OFF_IRQ_EN    8'h1C
`define DCT_OFF_PEND      8'h20

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define DCT_MC_MODE_LO    0
`define DCT_MC_MODE_HI    1
`define DCT_MC_EDGE_A     2
`define DCT_MC_EDGE_B     3
`define DCT_MC_A_FN_EN    4
`define DCT_MC_B_PRESET   5
`define DCT_MC_LEVEL      6
`define DCT_CK1_LO        0
`define DCT_CK1_HI        2
`define DCT_CK2_LO        4
`define DCT_CK2_HI        6
`define DCT_PEND_A        0
`define DCT_PEND_B        1
`define DCT_PEND_C        2
`define DCT_PEND_D        3

// ----------------------------------------------------------------
// Reset and preset values
// ----------------------------------------------------------------
`define DCT_CNT_RST       16'h0000
`define DCT_PRESET        16'hFFFF
`define DCT_PRESC_RST     8'h00
`define DCT_FLAGS_RST     4'h0

`endif

// *** dct_pkg.sv ***
package dct_pkg;

  // Operating mode of the timer
  typedef enum logic [1:0] {
    MODE_IDLE,
    MODE_DUAL_CAP,
    MODE_DUAL_IND,
    MODE_CAP_TMR
  } dct_mode_t;

  // Clock source of one counter
  typedef enum logic [2:0] {
    CKS_NONE,
    CKS_SYS,
    CKS_PRESC,
    CKS_EXT,
    CKS_ACC
  } dct_cks_t;

endpackage

// *** dct_evt_if.sv ***
`timescale 1ns/1ps

interface dct_evt_if;
  logic line_a;
  logic line_b;
  logic edge_sel_a;
  logic edge_sel_b;
  logic cap_a;
  logic cap_b;

  modport det  (input line_a, input line_b, input edge_sel_a, input edge_sel_b, output cap_a, output cap_b);
  modport core (output line_a, output line_b, output edge_sel_a, output edge_sel_b, input cap_a, input cap_b);
endinterface

// *** dct_edge_det.sv ***
`timescale 1ns/1ps

module dct_edge_det
  import dct_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Event carrier
  dct_evt_if.det   evt
);

  // ----------------------------------------------------------------
  // Previous levels of both lines
  // ----------------------------------------------------------------
  logic line_a_q;
  logic line_b_q;

  // Sample each line once per clock; pulses must last a cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      line_a_q <= 1'b0;
      line_b_q <= 1'b0;
    end else begin
      line_a_q <= evt.line_a;
      line_b_q <= evt.line_b;
    end
  end

  // Selected edge: 0 rising, 1 falling
  assign evt.cap_a = evt.edge_sel_a ? (line_a_q & ~evt.line_a) : (~line_a_q & evt.line_a);
  assign evt.cap_b = evt.edge_sel_b ? (line_b_q & ~evt.line_b) : (~line_b_q & evt.line_b);

endmodule

// *** dct_timer.sv ***
`timescale 1ns/1ps
`include "dct_cfg.svh"

// Function
// - Dual capture mode: selected edge on line A copies primary counter to first register.
// - Dual capture mode: selected edge on line B copies primary counter to second register.
// - Each capture line has its own rising/falling edge select bit.
// - With preset enabled, a dual capture stores the counter then loads 0xFFFF.
// - Captures A, B and primary underflow set own flags; interrupt only when enabled.
// - Dual capture mode: secondary counts down, underflow sets flag D, interrupt if enabled.
// - Dual capture mode: event or accumulate clock halts primary; secondary may use any.
// - Dual independent and capture-plus-timer: primary reloads from first register on underflow.
// - With output enabled, line A toggles each primary underflow, start level set by software.
// - Dual independent mode: primary underflow sets flag A, interrupt A when enabled.
// - Dual independent mode: secondary reloads from second register on underflow.
// - Dual independent mode: secondary underflow sets flag D, interrupt B when enabled.
// - Dual independent mode: line B may clock either counter; prescaled clock also usable.
// - Capture-plus-timer: line B edge copies secondary to second register, sets flag B.
// - Capture-plus-timer with preset: capture then load secondary with 0xFFFF.
// - Capture-plus-timer: secondary underflow sets flag D, interrupt B when enabled.
// - Capture-plus-timer: event or accumulate clock halts secondary; primary may use any.
// - Capture-plus-timer: each counter counts only once a clock source is enabled.
// - Level bit sets starting and present level of line A; set before clock.
// - Flags A, B, C drive interrupt A; flag D drives interrupt B, each enabled.
// - No-clock selection stops the corresponding counter.
module dct_timer
  import dct_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // Timer lines
  input  wire logic        line_a_i,
  output logic             line_a_o,
  output logic             line_a_oe,
  input  wire logic        line_b_i,
  // Interrupt lines
  output logic             irq_a,
  output logic             irq_b
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_s1_q;
  logic rst_s2_q;
  logic rst_sn;

  // Two-stage release of the asynchronous reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end
  assign rst_sn = rst_s2_q;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // Tick of one counter from its clock selection
  function automatic logic clk_tick(input dct_cks_t s, input logic ps, input logic ev,
                                    input logic lvl, input logic ext_ok);
    case (s)
      CKS_SYS:   clk_tick = 1'b1;
      CKS_PRESC: clk_tick = ps;
      CKS_EXT:   clk_tick = ext_ok & ev;
      CKS_ACC:   clk_tick = ext_ok & lvl;
      default:   clk_tick = 1'b0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [15:0] cnt1_q;
  logic [15:0] cnt2_q;
  logic [15:0] cap_first_q;
  logic [15:0] cap_second_q;
  logic [7:0]  presc_q;
  logic [7:0]  presc_cnt_q;
  dct_cks_t    cks1_q;
  dct_cks_t    cks2_q;
  dct_mode_t   mode_q;
  logic        edge_a_q;
  logic        edge_b_q;
  logic        a_fn_en_q;
  logic        b_preset_q;
  logic        level_q;
  logic [3:0]  irq_en_q;
  logic [3:0]  pend_q;
  logic [3:0]  pend_set;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  // Write decodes
  logic wr_cnt1;
  logic wr_cnt2;
  logic wr_mctrl;
  logic wr_pend;
  assign wr_cnt1  = reg_wr & hit(reg_addr, `DCT_OFF_CNT1);
  assign wr_cnt2  = reg_wr & hit(reg_addr, `DCT_OFF_CNT2);
  assign wr_mctrl = reg_wr & hit(reg_addr, `DCT_OFF_MCTRL);
  assign wr_pend  = reg_wr & hit(reg_addr, `DCT_OFF_PEND);

  // ----------------------------------------------------------------
  // Line edge detection
  // ----------------------------------------------------------------
  dct_evt_if evt ();

  assign evt.line_a     = line_a_i;
  assign evt.line_b     = line_b_i;
  assign evt.edge_sel_a = edge_a_q;
  assign evt.edge_sel_b = edge_b_q;

  dct_edge_det u_edge (
    .clk   (clk),
    .rst_n (rst_sn),
    .evt   (evt)
  );

  // ----------------------------------------------------------------
  // Event and tick decode
  // ----------------------------------------------------------------
  logic presc_tick;
  logic tick1;
  logic tick2;
  logic uf1;
  logic uf2;
  logic reload_mode;
  logic cap_a_ev;
  logic cap_b1_ev;
  logic cap_b2_ev;
  logic preset1;
  logic preset2;

  assign reload_mode = (mode_q == MODE_DUAL_IND) | (mode_q == MODE_CAP_TMR);
  assign presc_tick  = (presc_cnt_q == presc_q);

  // Line B may clock a counter unless it serves as capture input there
  assign tick1 = (mode_q != MODE_IDLE) &
                 clk_tick(cks1_q, presc_tick, evt.cap_b, line_b_i, mode_q != MODE_DUAL_CAP);
  assign tick2 = (mode_q != MODE_IDLE) &
                 clk_tick(cks2_q, presc_tick, evt.cap_b, line_b_i, mode_q != MODE_CAP_TMR);
  assign uf1   = tick1 & (cnt1_q == `DCT_CNT_RST);
  assign uf2   = tick2 & (cnt2_q == `DCT_CNT_RST);

  // Capture events per mode
  assign cap_a_ev  = (mode_q == MODE_DUAL_CAP) & evt.cap_a;
  assign cap_b1_ev = (mode_q == MODE_DUAL_CAP) & evt.cap_b;
  assign cap_b2_ev = (mode_q == MODE_CAP_TMR) & evt.cap_b;
  assign preset1   = (cap_a_ev & a_fn_en_q) | (cap_b1_ev & b_preset_q);
  assign preset2   = cap_b2_ev & b_preset_q;

  // ----------------------------------------------------------------
  // Prescaler
  // ----------------------------------------------------------------
  // Divides the system clock by presc_q + 1
  always_ff @(posedge clk or negedge rst_sn) begin
    if (!rst_sn) begin
      presc_cnt_q <= `DCT_PRESC_RST;
    end else if (presc_tick) begin
      presc_cnt_q <= `DCT_PRESC_RST;
    end else begin
      presc_cnt_q <= presc_cnt_q + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Counters
  // ----------------------------------------------------------------
  // Primary counter: preset, write, reload, then count
  always_ff @(posedge clk or negedge rst_sn) begin
    if (!rst_sn) begin
      cnt1_q <= `DCT_CNT_RST;
    end else if (preset1) begin
      cnt1_q <= `DCT_PRESET;
    end else if (wr_cnt1) begin
      cnt1_q <= reg_wdata[15:0];
    end else if (uf1 & reload_mode) begin
      cnt1_q <= cap_first_q;
    end else if (tick1) begin
      cnt1_q <= cnt1_q - 16'h0001;
    end
  end

  // Secondary counter: preset, write, reload, then count
  always_ff @(posedge clk or negedge rst_sn) begin
    if (!rst_sn) begin
      cnt2_q <= `DCT_CNT_RST;
    end else if (preset2) begin
      cnt2_q <= `DCT_PRESET;
    end else if (wr_cnt2) begin
      cnt2_q <= reg_wdata[15:0];
    end else if (uf2 & (mode_q == MODE_DUAL_IND)) begin
      cnt2_q <= cap_second_q;
    end else if (tick2) begin
      cnt2_q <= cnt2_q - 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Capture/reload registers
  // ----------------------------------------------------------------
  // First register: capture of primary on line A, else software
  always_ff @(posedge clk or negedge rst_sn) begin
    if (!rst_sn) begin
      cap_first_q <= `DCT_CNT_RST;
    end else if (cap_a_ev) begin
      cap_first_q <= cnt1_q;
    end else if (reg_wr & hit(reg_addr, `DCT_OFF_CAP_FIRST)) begin
      cap_first_q <= reg_wdata[15:0];
    end
  end

  // Second register: capture of primary or secondary on line B
  always_ff @(posedge clk or negedge rst_sn) begin
    if (!rst_sn) begin
      cap_second_q <= `DCT_CNT_RST;
    end else if (cap_b1_ev) begin
      cap_second_q <= cnt1_q;
    end else if (cap_b2_ev) begin
      cap_second_q <= cnt2_q;
    end else if (reg_wr & hit(reg_addr, `DCT_OFF_CAP_SEC)) begin
      cap_second_q <= reg_wdata[15:0];
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // Prescaler, clock selection and interrupt enables
  always_ff @(posedge clk or negedge rst_sn) begin
    if (!rst_sn) begin
      presc_q  <= `DCT_PRESC_RST;
      cks1_q   <= CKS_NONE;
      cks2_q   <= CKS_NONE;
      irq_en_q <= `DCT_FLAGS_RST;
    end else if (reg_wr) begin
      if (hit(reg_addr, `DCT_OFF_PRESC)) begin
        presc_q <= reg_wdata[7:0];
      end
      if (hit(reg_addr, `DCT_OFF_CKSEL)) begin
        cks1_q <= dct_cks_t'(reg_wdata[`DCT_CK1_HI:`DCT_CK1_LO]);
        cks2_q <= dct_cks_t'(reg_wdata[`DCT_CK2_HI:`DCT_CK2_LO]);
      end
      if (hit(reg_addr, `DCT_OFF_IRQ_EN)) begin
        irq_en_q <= reg_wdata[3:0];
      end
    end
  end

  // Mode control fields
  always_ff @(posedge clk or negedge rst_sn) begin
    if (!rst_sn) begin
      mode_q     <= MODE_IDLE;
      edge_a_q   <= 1'b0;
      edge_b_q   <= 1'b0;
      a_fn_en_q  <= 1'b0;
      b_preset_q <= 1'b0;
    end else if (wr_mctrl) begin
      mode_q     <= dct_mode_t'(reg_wdata[`DCT_MC_MODE_HI:`DCT_MC_MODE_LO]);
      edge_a_q   <= reg_wdata[`DCT_MC_EDGE_A];
      edge_b_q   <= reg_wdata[`DCT_MC_EDGE_B];
      a_fn_en_q  <= reg_wdata[`DCT_MC_A_FN_EN];
      b_preset_q <= reg_wdata[`DCT_MC_B_PRESET];
    end
  end

  // ----------------------------------------------------------------
  // Line A output
  // ----------------------------------------------------------------
  // Level set by software, toggled on underflow; toggle beats write
  always_ff @(posedge clk or negedge rst_sn) begin
    if (!rst_sn) begin
      level_q <= 1'b0;
    end else if (uf1 & reload_mode & a_fn_en_q) begin
      level_q <= ~level_q;
    end else if (wr_mctrl) begin
      level_q <= reg_wdata[`DCT_MC_LEVEL];
    end
  end

  assign line_a_o  = level_q;
  assign line_a_oe = a_fn_en_q & reload_mode;

  // ----------------------------------------------------------------
  // Pending flags and interrupts
  // ----------------------------------------------------------------
  assign pend_set[`DCT_PEND_A] = cap_a_ev | (uf1 & reload_mode);
  assign pend_set[`DCT_PEND_B] = cap_b1_ev | cap_b2_ev;
  assign pend_set[`DCT_PEND_C] = uf1 & (mode_q == MODE_DUAL_CAP);
  assign pend_set[`DCT_PEND_D] = uf2;

  // Sticky flags, write one to clear, set wins over clear
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_pend
      always_ff @(posedge clk or negedge rst_sn) begin
        if (!rst_sn) begin
          pend_q[gi] <= 1'b0;
        end else begin
          pend_q[gi] <= pend_set[gi] | (pend_q[gi] & ~(wr_pend & reg_wdata[gi]));
        end
      end
    end
  endgenerate

  assign irq_a = |(pend_q[2:0] & irq_en_q[2:0]);
  assign irq_b = pend_q[`DCT_PEND_D] & irq_en_q[`DCT_PEND_D];

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  // Read multiplexer; unmapped offsets read zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    case (reg_addr)
      `DCT_OFF_CNT1:      rdata_d = {16'h0000, cnt1_q};
      `DCT_OFF_CAP_FIRST: rdata_d = {16'h0000, cap_first_q};
      `DCT_OFF_CAP_SEC:   rdata_d = {16'h0000, cap_second_q};
      `DCT_OFF_CNT2:      rdata_d = {16'h0000, cnt2_q};
      `DCT_OFF_PRESC:     rdata_d = {24'h00_0000, presc_q};
      `DCT_OFF_CKSEL:     rdata_d = {25'h000_0000, cks2_q, 1'b0, cks1_q};
      `DCT_OFF_MCTRL:     rdata_d = {25'h000_0000, level_q, b_preset_q, a_fn_en_q, edge_b_q, edge_a_q, mode_q};
      `DCT_OFF_IRQ_EN:    rdata_d = {28'h000_0000, irq_en_q};
      `DCT_OFF_PEND:      rdata_d = {28'h000_0000, pend_q};
      default:            rdata_d = 32'h0000_0000;
    endcase
  end

  // Data stand only in the cycle after the read strobe
  always_ff @(posedge clk or negedge rst_sn) begin
    if (!rst_sn) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= reg_rd ? rdata_d : 32'h0000_0000;
    end
  end
  assign reg_rdata = rdata_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_cap_a;
    @(posedge clk) disable iff (!rst_sn)
    cap_a_ev |=> cap_first_q == $past(cnt1_q);
  endproperty
  a_cap_a: assert property (p_cap_a) else $error("line A capture lost");

  property p_cap_b;
    @(posedge clk) disable iff (!rst_sn)
    cap_b1_ev |=> cap_second_q == $past(cnt1_q);
  endproperty
  a_cap_b: assert property (p_cap_b) else $error("line B capture of primary lost");

  property p_edge_b;
    @(posedge clk) disable iff (!rst_sn)
    (mode_q == MODE_DUAL_CAP) && edge_b_q && !line_b_i && $past(line_b_i) && !$past(wr_mctrl) |-> cap_b1_ev;
  endproperty
  a_edge_b: assert property (p_edge_b) else $error("falling edge on line B missed");

  property p_preset1;
    @(posedge clk) disable iff (!rst_sn)
    cap_a_ev && a_fn_en_q |=> cnt1_q == 16'hFFFF && pend_q[0];
  endproperty
  a_preset1: assert property (p_preset1) else $error("primary preset missing");

  property p_irq;
    @(posedge clk) disable iff (!rst_sn)
    uf2 && irq_en_q[`DCT_PEND_D] && !reg_wr |=> irq_b;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt gating wrong");

  property p_halt1;
    @(posedge clk) disable iff (!rst_sn)
    (mode_q == MODE_DUAL_CAP) && ((cks1_q == CKS_EXT) || (cks1_q == CKS_ACC)) && !wr_cnt1 && !preset1
    |=> $stable(cnt1_q);
  endproperty
  a_halt1: assert property (p_halt1) else $error("primary ran on event clock");

  property p_reload1;
    @(posedge clk) disable iff (!rst_sn)
    uf1 && reload_mode && !wr_cnt1 |=> cnt1_q == $past(cap_first_q) && pend_q[0];
  endproperty
  a_reload1: assert property (p_reload1) else $error("primary reload wrong");

  property p_toggle;
    @(posedge clk) disable iff (!rst_sn)
    uf1 && reload_mode && a_fn_en_q |=> line_a_o != $past(line_a_o) && line_a_oe;
  endproperty
  a_toggle: assert property (p_toggle) else $error("line A did not toggle");

  property p_reload2;
    @(posedge clk) disable iff (!rst_sn)
    (mode_q == MODE_DUAL_IND) && uf2 && !wr_cnt2 |=> cnt2_q == $past(cap_second_q);
  endproperty
  a_reload2: assert property (p_reload2) else $error("secondary reload wrong");

  property p_pend_d;
    @(posedge clk) disable iff (!rst_sn)
    uf2 |=> pend_q[3];
  endproperty
  a_pend_d: assert property (p_pend_d) else $error("flag D not set");

  property p_cap2;
    @(posedge clk) disable iff (!rst_sn)
    cap_b2_ev |=> cap_second_q == $past(cnt2_q) && pend_q[1];
  endproperty
  a_cap2: assert property (p_cap2) else $error("secondary capture lost");

  property p_stop2;
    @(posedge clk) disable iff (!rst_sn)
    ((cks2_q == CKS_NONE) && !wr_cnt2 && !preset2) [*2] |-> $stable(cnt2_q);
  endproperty
  a_stop2: assert property (p_stop2) else $error("secondary ran without clock");

  property p_wrap1;
    @(posedge clk) disable iff (!rst_sn)
    (mode_q == MODE_DUAL_CAP) && uf1 && !wr_cnt1 && !preset1 |=> cnt1_q == 16'hFFFF && pend_q[2];
  endproperty
  a_wrap1: assert property (p_wrap1) else $error("primary did not wrap");

endmodule

// *** dct_line_model.sv ***
`timescale 1ns/1ps

// ----------------------------------------------------------------
// External source of the two timer lines
// ----------------------------------------------------------------
module dct_line_model (
  // Clock
  input  wire logic clk,
  // Timer lines
  output logic      line_a,
  output logic      line_b
);
  // Both lines idle low
  initial begin
    line_a = 1'b0;
    line_b = 1'b0;
  end

  // Drive one line, hold the level two clocks so it is sampled
  task automatic drive(input logic sel, input logic v);
    @(posedge clk);
    if (sel) begin
      line_b <= v;
    end else begin
      line_a <= v;
    end
    repeat (2) @(posedge clk);
  endtask

  // Pulse to v and back
  task automatic pulse(input logic sel, input logic v);
    drive(sel, v);
    drive(sel, !v);
  endtask
endmodule

// *** dual_capture_timer_modes_test.sv ***
`timescale 1ns/1ps
`include "dct_cfg.svh"

`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end

module dual_capture_timer_modes_test;
  import dct_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        clk, rst_n, reg_wr, reg_rd, line_a_o, line_a_oe, irq_a, irq_b;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, v;
  wire logic   line_a_i, line_b_i;
  int          n_fail, checks_done, n;
  logic        prev;

  // Block under test and line source
  dct_timer dct_timer_i (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .line_a_i(line_a_i),
    .line_a_o(line_a_o), .line_a_oe(line_a_oe), .line_b_i(line_b_i), .irq_a(irq_a), .irq_b(irq_b));
  dct_line_model dct_line_model_i (.clk(clk), .line_a(line_a_i), .line_b(line_b_i));

  // Clock, 40 ns period
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Register write, one strobe cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1; // Settle so checks see the new state
  endtask

  // Register read, data taken in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask

  // Read and compare
  task automatic chk_rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    rd(a);
    `CHK(nm, e, v)
  endtask

  // Mode 1: captures with opposite edges, preset on line A
  task automatic t_dual_cap;
    wr(`DCT_OFF_CKSEL, 32'h00000000);
    wr(`DCT_OFF_CNT1, 32'h00001234);
    wr(`DCT_OFF_IRQ_EN, 32'h00000000);
    wr(`DCT_OFF_MCTRL, 32'h00000019);
    dct_line_model_i.drive(1'b1, 1'b1);
    dct_line_model_i.drive(1'b0, 1'b1);
    chk_rd("cap first", `DCT_OFF_CAP_FIRST, 32'h00001234);
    chk_rd("cnt1 preset", `DCT_OFF_CNT1, 32'h0000FFFF);
    dct_line_model_i.drive(1'b0, 1'b0);
    dct_line_model_i.drive(1'b1, 1'b0);
    chk_rd("cap second", `DCT_OFF_CAP_SEC, 32'h0000FFFF);
    chk_rd("pend", `DCT_OFF_PEND, 32'h00000003);
    `CHK("irq_a off", 1'b0, irq_a)
    wr(`DCT_OFF_IRQ_EN, 32'h00000002);
    `CHK("irq_a on", 1'b1, irq_a)
    wr(`DCT_OFF_PEND, 32'h00000002);
    `CHK("irq_a clr", 1'b0, irq_a)
    wr(`DCT_OFF_CKSEL, 32'h00000004);
    dct_line_model_i.drive(1'b1, 1'b1);
    chk_rd("cnt1 halt", `DCT_OFF_CNT1, 32'h0000FFFF);
  endtask

  // Mode 2: two reloading timers, line A square wave, event clock
  task automatic t_dual_ind;
    wr(`DCT_OFF_CKSEL, 32'h00000000);
    wr(`DCT_OFF_PEND, 32'h0000000F);
    wr(`DCT_OFF_CAP_FIRST, 32'h00000003);
    wr(`DCT_OFF_CAP_SEC, 32'h00000001);
    wr(`DCT_OFF_CNT1, 32'h00000000);
    wr(`DCT_OFF_CNT2, 32'h00000000);
    wr(`DCT_OFF_IRQ_EN, 32'h00000009);
    wr(`DCT_OFF_MCTRL, 32'h00000052);
    `CHK("oe", 1'b1, line_a_oe)
    `CHK("start level", 1'b1, line_a_o)
    wr(`DCT_OFF_CKSEL, 32'h00000011);
    prev = line_a_o;
    n = 0;
    repeat (40) begin
      @(posedge clk);
      #1;
      if (line_a_o !== prev) n++;
      prev = line_a_o;
    end
    wr(`DCT_OFF_CKSEL, 32'h00000000);
    `CHK("toggles", 10, n)
    chk_rd("pend", `DCT_OFF_PEND, 32'h00000009);
    `CHK("irq a b", 2'b11, {irq_a, irq_b})
    chk_rd("cnt1 reload", `DCT_OFF_CNT1, 32'h00000002);
    chk_rd("cnt2 reload", `DCT_OFF_CNT2, 32'h00000000);
    wr(`DCT_OFF_CNT2, 32'h00000005);
    wr(`DCT_OFF_CKSEL, 32'h00000030);
    repeat (3) dct_line_model_i.pulse(1'b1, 1'b0);
    chk_rd("cnt2 events", `DCT_OFF_CNT2, 32'h00000002);
    wr(`DCT_OFF_PRESC, 32'h00000003);
    wr(`DCT_OFF_CNT2, 32'h00000010);
    wr(`DCT_OFF_CKSEL, 32'h00000020);
    repeat (16) @(posedge clk);
    wr(`DCT_OFF_CKSEL, 32'h00000000);
    chk_rd("cnt2 prescaled", `DCT_OFF_CNT2, 32'h0000000C);
  endtask

  // Mode 3: line B captures the secondary counter
  task automatic t_cap_tmr;
    wr(`DCT_OFF_CKSEL, 32'h00000000);
    wr(`DCT_OFF_CNT2, 32'h00000042);
    wr(`DCT_OFF_PEND, 32'h0000000F);
    wr(`DCT_OFF_IRQ_EN, 32'h00000002);
    wr(`DCT_OFF_MCTRL, 32'h00000023);
    dct_line_model_i.pulse(1'b1, 1'b0);
    chk_rd("cap second", `DCT_OFF_CAP_SEC, 32'h00000042);
    chk_rd("cnt2 preset", `DCT_OFF_CNT2, 32'h0000FFFF);
    chk_rd("pend", `DCT_OFF_PEND, 32'h00000002);
    `CHK("irq_a", 1'b1, irq_a)
    wr(`DCT_OFF_MCTRL, 32'h00000003);
    wr(`DCT_OFF_CKSEL, 32'h00000030);
    wr(`DCT_OFF_CNT2, 32'h00000010);
    dct_line_model_i.pulse(1'b1, 1'b0);
    chk_rd("cnt2 halt", `DCT_OFF_CNT2, 32'h00000010);
  endtask

  // Mode 1: secondary wraps past zero without reload
  task automatic t_wrap;
    wr(`DCT_OFF_CKSEL, 32'h00000000);
    wr(`DCT_OFF_PEND, 32'h0000000F);
    wr(`DCT_OFF_MCTRL, 32'h00000001);
    wr(`DCT_OFF_CNT2, 32'h00000000);
    wr(`DCT_OFF_CNT1, 32'h00000000);
    wr(`DCT_OFF_IRQ_EN, 32'h00000008);
    wr(`DCT_OFF_CKSEL, 32'h00000011);
    wr(`DCT_OFF_CKSEL, 32'h00000000);
    chk_rd("cnt2 wrap", `DCT_OFF_CNT2, 32'h0000FFFE);
    chk_rd("cnt1 wrap", `DCT_OFF_CNT1, 32'h0000FFFE);
    chk_rd("pend", `DCT_OFF_PEND, 32'h0000000C);
    `CHK("irq_b", 1'b1, irq_b)
  endtask

  // Verdict and end of run
  task automatic end_sim;
    if (n_fail == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    end_sim;
  end

  // Main sequence
  initial begin
    n_fail = 0;
    checks_done = 0;
    rst_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h00000000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK("irq reset", 2'b00, {irq_a, irq_b})
    t_dual_cap;
    t_dual_ind;
    t_cap_tmr;
    t_wrap;
    end_sim;
  end
endmodule
